//--- src/rcs_consts.svh
// Offsets, field positions, reset values and timing counts of the clock control block
`ifndef RCS_CONSTS_SVH
`define RCS_CONSTS_SVH
// ----------------------------------------
// Register map
// ----------------------------------------
`define RCS_ADDR_CTRL 8'h04
`define RCS_ADDR_HOLD 8'h08
`define RCS_ADDR_TIMER 8'h0C
// ----------------------------------------
// Control register fields
// ----------------------------------------
`define RCS_BIT_OSC_EN 7
`define RCS_BIT_LCD_EN 6
`define RCS_BIT_FAIL 5
`define RCS_BIT_RUN 4
`define RCS_BIT_AEN 3
`define RCS_BIT_ALARM_FLAG_AUTORESET 2
`define RCS_BIT_LOAD 1
`define RCS_BIT_SNAP 0
`define RCS_CTRL_RESET 8'h00
// ----------------------------------------
// Timing and bus response codes
// ----------------------------------------
`define RCS_CMD_CYCLES 4
`define RCS_LOST_CYCLES 64
`define RCS_RESP_OKAY 2'b00
`define RCS_RESP_SLVERR 2'b10
`endif

//--- src/rcs_pkg.sv
// Types shared by the clock control block
package rcs_pkg;
	typedef enum logic [1:0] {
		RCS_IDLE = 2'b00,
		RCS_LOAD = 2'b01,
		RCS_SNAP = 2'b10
	} rcs_cmd_state_t;
	typedef logic [31:0] rcs_word_t;
endpackage

//--- src/rcs_lost_clock.sv
// Missing slow clock detector
`timescale 1ns/1ps
`include "rcs_consts.svh"
module rcs_lost_clock #(
	parameter int LOST_CYCLES = `RCS_LOST_CYCLES
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic enable,
	input wire logic slow_clk_pin,
	output logic lost
);
	// The cycle counter is 16 bits wide
	if (LOST_CYCLES < 2 || LOST_CYCLES > 65535) $error("LOST_CYCLES out of range");
	logic sync_a;
	logic sync_b;
	logic sync_c;
	logic [15:0] count;
	// ----------------------------------------
	// Pin synchroniser; the second and third stages feed the edge detector
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync_a <= 1'b0;
			sync_b <= 1'b0;
			sync_c <= 1'b0;
		end else begin
			sync_a <= slow_clk_pin;
			sync_b <= sync_a;
			sync_c <= sync_b;
		end
	end
	// Count cycles since the last slow clock edge; a pulse when the limit is hit
	always_ff @(posedge aclk) begin
		if (!aresetn || !enable || (sync_b != sync_c)) begin
			count <= 16'h0000;
			lost <= 1'b0;
		end else begin
			lost <= (count == 16'(LOST_CYCLES - 1));
			if (count != 16'(LOST_CYCLES)) begin
				count <= count + 16'h0001;
			end
		end
	end
endmodule

//--- src/rcs_timer.sv
// Timer with run control, load and alarm match
`timescale 1ns/1ps
module rcs_timer (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic tick,
	input wire logic run,
	input wire logic load,
	input wire logic [31:0] load_value,
	input wire logic [31:0] alarm_value,
	input wire logic alarm_en,
	input wire logic auto_reset,
	output logic [31:0] count,
	output logic alarm_hit
);
	// Hold the count while stopped; auto reset restarts from zero on a match
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			count <= 32'h0000_0000;
			alarm_hit <= 1'b0;
		end else begin
			alarm_hit <= 1'b0;
			if (load) begin
				count <= load_value;
			end else if (run && tick) begin // RQ3
				if (alarm_en && count == alarm_value) begin
					alarm_hit <= 1'b1;
					count <= auto_reset ? 32'h0000_0000 : count + 32'h0000_0001; // RQ7
				end else begin
					count <= count + 32'h0000_0001;
				end
			end
		end
	end
endmodule

//--- src/rcs_top.sv
// Control and status register of the low power clock, on AXI4-Lite
`timescale 1ns/1ps
`include "rcs_consts.svh"
// Functional notes
// RQ1: Bit 6 enables the missing slow clock detector; zero disables it. Here the detector runs only while bit 7 is also set.
// RQ2: Hardware sets fail flag bit 5 on lost clock; software clears it.
// RQ3: Run bit 4 lets the timer count; zero stops and holds the count.
// RQ4: Bit 3 enables alarm; any write to it clears the alarm flag.
// RQ5: Writing 1 to bit 1 loads holding value; hardware clears when done.
// RQ6: Writing 1 to bit 0 snapshots timer; hardware clears when done.
// RQ7: Bit 2 reads alarm flag; writes store the auto reset selection.
module rcs_top #(
	parameter int CMD_CYCLES = `RCS_CMD_CYCLES,
	parameter int LOST_CYCLES = `RCS_LOST_CYCLES,
	parameter int TICK_DIV = 4
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic slow_clk_pin,
	output logic slow_osc_enable,
	output logic alarm_event
);
	import rcs_pkg::*;
	// Counters are 8 and 16 bits wide; refuse values they cannot hold
	if (CMD_CYCLES < 1 || CMD_CYCLES > 255) $error("CMD_CYCLES out of range");
	if (TICK_DIV < 1 || TICK_DIV > 65535) $error("TICK_DIV out of range");
	// ----------------------------------------
	// Register state
	// ----------------------------------------
	logic lost_clock_detect_enable;
	logic osc_fail_flag;
	logic timer_run;
	logic alarm_enable;
	logic alarm_flag;
	logic auto_reset;
	logic timer_load_cmd;
	logic timer_snapshot_cmd;
	rcs_word_t hold;
	rcs_word_t alarm_match;
	rcs_word_t timer_count;
	logic alarm_hit;
	logic lost;
	logic [7:0] aw_addr;
	logic aw_have;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic w_have;
	rcs_cmd_state_t cmd_state;
	logic [7:0] cmd_count;
	logic do_load;
	logic [15:0] div_count;
	logic tick;
	logic wr_fire;
	logic wr_ctrl;
	logic wr_byte0;

	// Byte lane zero covers every control bit
	function automatic logic lane0(input logic [3:0] strb);
		return strb[0];
	endfunction

	assign wr_fire = aw_have && w_have && !s_axi_bvalid;
	assign wr_ctrl = wr_fire && aw_addr == `RCS_ADDR_CTRL;
	assign wr_byte0 = lane0(w_strb);

	// ----------------------------------------
	// Write address and data capture, either order
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have <= 1'b0;
			aw_addr <= 8'h00;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_have <= 1'b1;
			aw_addr <= s_axi_awaddr;
		end else if (wr_fire) begin
			aw_have <= 1'b0;
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_have <= 1'b0;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_have <= 1'b1;
			w_data <= s_axi_wdata;
			w_strb <= s_axi_wstrb;
		end else if (wr_fire) begin
			w_have <= 1'b0;
		end
	end
	// Ready only while the slot is empty, so one write is in flight at a time
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
		end else begin
			s_axi_awready <= !aw_have && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
			s_axi_wready <= !w_have && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
		end
	end
	// Write response; unmapped addresses answer SLVERR
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RCS_RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= (aw_addr == `RCS_ADDR_CTRL || aw_addr == `RCS_ADDR_HOLD
				|| aw_addr == `RCS_ADDR_TIMER) ? `RCS_RESP_OKAY : `RCS_RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ----------------------------------------
	// Control bits written by software
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			slow_osc_enable <= 1'b0;
			lost_clock_detect_enable <= 1'b0;
			timer_run <= 1'b0;
			alarm_enable <= 1'b0;
			auto_reset <= 1'b0;
		end else if (wr_ctrl && wr_byte0) begin
			slow_osc_enable <= w_data[`RCS_BIT_OSC_EN];
			lost_clock_detect_enable <= w_data[`RCS_BIT_LCD_EN]; // RQ1
			timer_run <= w_data[`RCS_BIT_RUN]; // RQ3
			alarm_enable <= w_data[`RCS_BIT_AEN]; // RQ4
			auto_reset <= w_data[`RCS_BIT_ALARM_FLAG_AUTORESET]; // RQ7
		end
	end
	// Fail flag: a detection in the clearing cycle wins over the clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			osc_fail_flag <= 1'b0;
		end else if (lost) begin
			osc_fail_flag <= 1'b1; // RQ2
		end else if (wr_ctrl && wr_byte0 && !w_data[`RCS_BIT_FAIL]) begin
			osc_fail_flag <= 1'b0; // RQ2
		end
	end
	// Alarm flag: any control write with byte lane zero clears it, a match in the same cycle wins
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			alarm_flag <= 1'b0;
		end else if (alarm_hit) begin
			alarm_flag <= 1'b1;
		end else if (wr_ctrl && wr_byte0) begin
			alarm_flag <= 1'b0; // RQ4
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			alarm_event <= 1'b0;
		end else begin
			alarm_event <= alarm_flag;
		end
	end
	// Holding word and alarm match value
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hold <= 32'h0000_0000;
		end else if (cmd_state == RCS_SNAP && cmd_count == 8'h00) begin
			hold <= timer_count; // RQ6
		end else if (wr_fire && aw_addr == `RCS_ADDR_HOLD) begin
			for (int i = 0; i < 4; i++) begin
				if (w_strb[i]) begin
					hold[i*8 +: 8] <= w_data[i*8 +: 8];
				end
			end
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			alarm_match <= 32'h0000_0000;
		end else if (wr_fire && aw_addr == `RCS_ADDR_TIMER) begin
			for (int i = 0; i < 4; i++) begin
				if (w_strb[i]) begin
					alarm_match[i*8 +: 8] <= w_data[i*8 +: 8];
				end
			end
		end
	end

	// ----------------------------------------
	// Load and snapshot sequencer
	// ----------------------------------------
	// Commands take a few cycles, modelling the slow domain transfer; bits read 1 meanwhile
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cmd_state <= RCS_IDLE;
			cmd_count <= 8'h00;
			timer_load_cmd <= 1'b0;
			timer_snapshot_cmd <= 1'b0;
		end else begin
			unique case (cmd_state)
				RCS_IDLE: begin
					if (wr_ctrl && wr_byte0 && w_data[`RCS_BIT_LOAD]) begin
						cmd_state <= RCS_LOAD;
						cmd_count <= 8'(CMD_CYCLES - 1);
						timer_load_cmd <= 1'b1; // RQ5
					end else if (wr_ctrl && wr_byte0 && w_data[`RCS_BIT_SNAP]) begin
						cmd_state <= RCS_SNAP;
						cmd_count <= 8'(CMD_CYCLES - 1);
						timer_snapshot_cmd <= 1'b1; // RQ6
					end
				end
				RCS_LOAD, RCS_SNAP: begin
					if (cmd_count == 8'h00) begin
						cmd_state <= RCS_IDLE;
						timer_load_cmd <= 1'b0; // RQ5
						timer_snapshot_cmd <= 1'b0; // RQ6
					end else begin
						cmd_count <= cmd_count - 8'h01;
					end
				end
				default: begin
					cmd_state <= RCS_IDLE;
				end
			endcase
		end
	end
	assign do_load = cmd_state == RCS_LOAD && cmd_count == 8'h00; // RQ5

	// Slow tick divider; one pulse every TICK_DIV cycles while the oscillator runs
	always_ff @(posedge aclk) begin
		if (!aresetn || !slow_osc_enable) begin
			div_count <= 16'h0000;
			tick <= 1'b0;
		end else begin
			tick <= (div_count == 16'(TICK_DIV - 1));
			div_count <= (div_count == 16'(TICK_DIV - 1)) ? 16'h0000 : div_count + 16'h0001;
		end
	end

	rcs_timer u_timer (
		.aclk(aclk),
		.aresetn(aresetn),
		.tick(tick),
		.run(timer_run),
		.load(do_load),
		.load_value(hold),
		.alarm_value(alarm_match),
		.alarm_en(alarm_enable),
		.auto_reset(auto_reset),
		.count(timer_count),
		.alarm_hit(alarm_hit)
	);
	rcs_lost_clock #(
		.LOST_CYCLES(LOST_CYCLES)
	) u_lost (
		.aclk(aclk),
		.aresetn(aresetn),
		.enable(lost_clock_detect_enable && slow_osc_enable), // RQ1
		.slow_clk_pin(slow_clk_pin),
		.lost(lost)
	);

	// ----------------------------------------
	// Read channel
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `RCS_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= `RCS_RESP_OKAY;
			unique case (s_axi_araddr)
				`RCS_ADDR_CTRL: s_axi_rdata <= {24'h00_0000, slow_osc_enable,
					lost_clock_detect_enable, osc_fail_flag, timer_run, alarm_enable,
					alarm_flag, timer_load_cmd, timer_snapshot_cmd}; // RQ7
				`RCS_ADDR_HOLD: s_axi_rdata <= hold;
				`RCS_ADDR_TIMER: s_axi_rdata <= alarm_match;
				default: begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= `RCS_RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rvalid) begin
			if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end else begin
			s_axi_arready <= 1'b1;
		end
	end
endmodule

//--- dv/rcs_top_monitor.sv
// Bus handshake and output checks for the clock control block
`timescale 1ns/1ps
`include "rcs_consts.svh"
module rcs_top_monitor (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic slow_osc_enable
);
	// ----------------------------------------
	// Checks, all in the one clock domain
	// ----------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
	rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
	wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
		s_axi_wready |-> ##[1:3] s_axi_bvalid) else $error("write answer late");
	wr_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken during answer");
	rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid &&
		!s_axi_arready) else $error("read answer late");
	// Unmapped places answer zero with an error so software sees the slip
	rd_unmapped_a: assert property (s_axi_arvalid && s_axi_arready &&
		!(s_axi_araddr inside {8'h04, 8'h08, 8'h0C}) |=>
		s_axi_rresp == `RCS_RESP_SLVERR && s_axi_rdata == 32'h0) else $error("bad unmapped read");
	ctrl_upper_a: assert property (s_axi_arvalid && s_axi_arready &&
		s_axi_araddr == `RCS_ADDR_CTRL |=> s_axi_rdata[31:8] == 24'h0 &&
		s_axi_rresp == `RCS_RESP_OKAY) else $error("bad control read");
	// Oscillator enable moves only with a write answer
	osc_change_a: assert property ($changed(slow_osc_enable) |-> $rose(s_axi_bvalid))
		else $error("oscillator enable moved alone");
	cover property (s_axi_bvalid && s_axi_bresp == `RCS_RESP_SLVERR);
	cover property (s_axi_rvalid && s_axi_rresp == `RCS_RESP_SLVERR);
	cover property ($rose(slow_osc_enable));
endmodule

//--- dv/rcs_top_test.sv
// Self-checking bench of the clock control block
`timescale 1ns/1ps
`include "rcs_consts.svh"
module rcs_top_test;
	import rcs_pkg::*;
	logic aclk = 0;
	logic aresetn = 0;
	logic [7:0] awaddr = 0;
	logic [7:0] araddr = 0;
	logic awvalid = 0;
	logic wvalid = 0;
	logic arvalid = 0;
	logic pin = 0;
	logic clk_on = 1;
	rcs_word_t wdata = 0;
	logic awready, wready, bvalid, arready, rvalid, osc_en, alarm;
	logic [1:0] bresp, rresp;
	rcs_word_t rdata;
	logic [3:0] wstrb = 4'hF;
	rcs_word_t got;
	logic [1:0] gr;
	int miscompares = 0;
	int cmp_count = 0;
	int cyc = 0;
	logic [31:0] tw [5] = '{32'h0000_0080, 32'h0000_0090, 32'h0000_00C4, 32'h0000_00E0,
		32'hFFFF_FF08};
	logic [31:0] te [5] = '{32'h0000_0080, 32'h0000_0090, 32'h0000_00C0, 32'h0000_00C0,
		32'h0000_0008};
	rcs_top #(.CMD_CYCLES(4), .LOST_CYCLES(8), .TICK_DIV(4)) dut (
		.aclk, .aresetn, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
		.slow_clk_pin(pin), .slow_osc_enable(osc_en), .alarm_event(alarm));
	// ----------------------------------------
	// Clocks and hang guard
	// ----------------------------------------
	always #2.5 aclk = ~aclk;
	// Slow clock toggles while allowed; stopping it starves the detector
	always @(posedge aclk) if (clk_on) pin <= ~pin;
	// A hang counts as a mismatch
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 5000) begin
			miscompares++;
			wrap_up();
		end
	end
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			miscompares++;
			$display("MISMATCH t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	// Address and data offered together, each released once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er = `RCS_RESP_OKAY);
		logic ta;
		logic tw2;
		ta = 0;
		tw2 = 0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1;
		wvalid <= 1;
		while (!(ta && tw2)) begin
			@(posedge aclk);
			if (awready && !ta) begin
				ta = 1;
				awvalid <= 0;
			end
			if (wready && !tw2) begin
				tw2 = 1;
				wvalid <= 0;
			end
		end
		do @(posedge aclk); while (!bvalid);
		chk({30'h0, bresp}, {30'h0, er});
	endtask
	// Read data and response are taken at the edge where rvalid is sampled high
	task automatic rd(input logic [7:0] a, output rcs_word_t d, output logic [1:0] r);
		araddr <= a;
		arvalid <= 1;
		do @(posedge aclk); while (!arready);
		arvalid <= 0;
		do @(posedge aclk); while (!rvalid);
		d = rdata;
		r = rresp;
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] e,
		input logic [1:0] er = `RCS_RESP_OKAY);
		rcs_word_t d;
		logic [1:0] r;
		rd(a, d, r);
		chk(d, e);
		chk({30'h0, r}, {30'h0, er});
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge aclk);
	endtask
	task automatic wrap_up();
		$display("compares %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		idle(8);
		aresetn <= 1;
		idle(1);
		chk({30'h0, osc_en, alarm}, 32'h0);
		rc(`RCS_ADDR_CTRL, 32'h0000_0000);
		// Ordinary rows: write control, read back, oscillator output follows bit 7
		for (int i = 0; i < 5; i++) begin
			wr(`RCS_ADDR_CTRL, tw[i]);
			rc(`RCS_ADDR_CTRL, te[i]);
			chk({31'h0, osc_en}, {31'h0, tw[i][7]});
		end
		// Load then snapshot with the timer stopped: value comes back unchanged
		wr(`RCS_ADDR_HOLD, 32'h1234_5678);
		wr(`RCS_ADDR_CTRL, 32'h0000_0082);
		rc(`RCS_ADDR_CTRL, 32'h0000_0082);
		idle(10);
		rc(`RCS_ADDR_CTRL, 32'h0000_0080);
		wr(`RCS_ADDR_HOLD, 32'h0);
		wr(`RCS_ADDR_CTRL, 32'h0000_0081);
		rc(`RCS_ADDR_CTRL, 32'h0000_0081);
		idle(10);
		rc(`RCS_ADDR_CTRL, 32'h0000_0080);
		rc(`RCS_ADDR_HOLD, 32'h1234_5678);
		// Running timer moves past the loaded value
		wr(`RCS_ADDR_CTRL, 32'h0000_0090);
		idle(40);
		wr(`RCS_ADDR_CTRL, 32'h0000_0091);
		idle(10);
		rd(`RCS_ADDR_HOLD, got, gr);
		chk({31'h0, got > 32'h1234_5678 && got < 32'h1234_5700}, 32'h1);
		// Lost slow clock sets a sticky fail flag, cleared by a zero write
		clk_on <= 0;
		wr(`RCS_ADDR_CTRL, 32'h0000_00C0);
		idle(40);
		rc(`RCS_ADDR_CTRL, 32'h0000_00E0);
		clk_on <= 1;
		idle(20);
		rc(`RCS_ADDR_CTRL, 32'h0000_00E0);
		wr(`RCS_ADDR_CTRL, 32'h0000_00C0);
		rc(`RCS_ADDR_CTRL, 32'h0000_00C0);
		clk_on <= 0;
		wr(`RCS_ADDR_CTRL, 32'h0000_0080);
		idle(40);
		rc(`RCS_ADDR_CTRL, 32'h0000_0080);
		clk_on <= 1;
		// Alarm at count 5, flag read on bit 2, any enable write clears it
		wr(`RCS_ADDR_TIMER, 32'h0000_0005);
		wr(`RCS_ADDR_HOLD, 32'h0);
		wr(`RCS_ADDR_CTRL, 32'h0000_0082);
		idle(10);
		wr(`RCS_ADDR_CTRL, 32'h0000_0098);
		idle(60);
		chk({31'h0, alarm}, 32'h1);
		rc(`RCS_ADDR_CTRL, 32'h0000_009C);
		wr(`RCS_ADDR_CTRL, 32'h0000_0098);
		idle(2);
		chk({31'h0, alarm}, 32'h0);
		rc(`RCS_ADDR_CTRL, 32'h0000_0098);
		// Control write without byte lane zero answers but changes nothing
		wstrb <= 4'hE;
		wr(`RCS_ADDR_CTRL, 32'h0000_0000);
		wstrb <= 4'hF;
		rc(`RCS_ADDR_CTRL, 32'h0000_0098);
		// Auto reset restarts the count on each match, so it never passes five
		wr(`RCS_ADDR_CTRL, 32'h0000_0086);
		idle(10);
		wr(`RCS_ADDR_CTRL, 32'h0000_009C);
		idle(40);
		rc(`RCS_ADDR_CTRL, 32'h0000_009C);
		wr(`RCS_ADDR_CTRL, 32'h0000_009D);
		idle(10);
		rd(`RCS_ADDR_HOLD, got, gr);
		chk({31'h0, got <= 32'h0000_0005}, 32'h1);
		// Unmapped place is refused both ways
		wr(8'h10, 32'h0000_0001, `RCS_RESP_SLVERR);
		rc(8'h10, 32'h0, `RCS_RESP_SLVERR);
		wrap_up();
	end
endmodule
bind rcs_top rcs_top_monitor mon (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
	.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
	.s_axi_rvalid, .s_axi_rready, .slow_osc_enable);
